// ===== sdcif_defs.vh
// constants for the diagnostic channel and interrupt framer
`ifndef SDCIF_DEFS_VH
`define SDCIF_DEFS_VH
// ----------------------------------------------------------------
// channel entry
// ----------------------------------------------------------------
`define SDCIF_CHAN_CODE      2'h2
`define SDCIF_CHAN_BYTES     8'h03
`define SDCIF_DIAG_MAX       8'h7F
`define SDCIF_ERR_FIELD_W    5
// ----------------------------------------------------------------
// interrupt section
// ----------------------------------------------------------------
`define SDCIF_INT_LEN        6'h14
`define SDCIF_INT_CODE       2'h0
`define SDCIF_INT_TYPE_DIAG  7'h01
`define SDCIF_INT_BYTES      8'h0C
`define SDCIF_SEQ_MAX        5'h1F
`define SDCIF_ST_IN          2'h1
`define SDCIF_ST_OUT         2'h2
`define SDCIF_CLS_DIG        4'hF
`define SDCIF_CLS_ANA        4'h5
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SDCIF_A_CTRL         4'h0
`define SDCIF_A_ENA          4'h1
`define SDCIF_A_BASE         4'h2
`define SDCIF_A_CHAN         4'h3
`define SDCIF_A_INT0         4'h4
`define SDCIF_A_INT1         4'h5
`define SDCIF_A_EVT          4'h6
`define SDCIF_A_START        4'h7
`define SDCIF_A_STAT         4'h8
`define SDCIF_A_SEQ          4'h9
`endif

// ===== sdcif_framer.v
// diagnostic channel entry and interrupt section framer
`timescale 1ns/1ps
// Overview of operation
// - channel entry byte 0: code 10 in bits 7..6, module id in 5..0
// - module id equals slot number minus one
// - byte 1: channel number in 5..0, direction 01/10/11 in 7..6
// - byte 2 bits 4..0 hold standard error code 00001..01001
// - maker error codes 10000, 10001, 10010 in same field
// - byte 2 bits 7..5 give channel type 001..110
// - each channel entry is exactly three bytes
// - entries limited so whole telegram stays within 127 bytes
// - entries only for modules with channel diagnostics enabled
// - one interrupt per telegram, section at most twelve bytes
// - enabled interrupt section always comes last
// - interrupt byte 0: length 010100 in 5..0, code 00 in 7..6
// - byte 1: type 0000001 in 6..0, bit 7 interrupt code bit
// - byte 2: slot number one to twenty as full byte
// - byte 3 bits 1..0: 01 arriving, 10 leaving, never 00 or 11
// - byte 3 bit 2 zero, sequence number 0..31 in bits 7..3
// - byte 4 bit 0 flags ack timeout fault, bits 7..1 reserved
// - byte 5: class 1111 digital, 0101 analog, upper bits reserved
// - byte 6: module kind 70h..73h
// - byte 7 channel count, then rack address high then low
// - byte 10 event bits for channels 7..0
// - byte 11 event bits for channels 15..8, ends section
`include "sdcif_defs.vh"
module sdcif_framer #(
  parameter NSLOT = 20
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire [3:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  output wire        out_valid,
  input  wire        out_ready,
  output reg  [7:0]  out_data,
  output reg         out_last
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg        int_en;
  reg [6:0]  base_len;
  reg [19:0] chan_ena;
  reg [4:0]  c_slot;
  reg [5:0]  c_chan;
  reg [1:0]  c_dir;
  reg [4:0]  c_err;
  reg [2:0]  c_type;
  reg [4:0]  i_slot;
  reg        i_leave;
  reg        i_fault;
  reg        i_ana;
  reg [1:0]  i_kind;
  reg [7:0]  i_nch;
  reg [15:0] i_addr;
  reg [15:0] i_evt;
  reg        i_pend;
  reg [4:0]  seq;
  reg [6:0]  used;
  reg [7:0]  dropped;
  reg        busy;
  reg        is_int;
  reg [3:0]  idx;
  reg        sent_int;
  reg        valid;
  assign out_valid = valid;
  wire       slot_ok = (c_slot != 5'h00) && (c_slot <= NSLOT[4:0]);
  wire       chan_ok = slot_ok && chan_ena[c_slot - 5'h01];
  wire [7:0] int_room = int_en ? `SDCIF_INT_BYTES : 8'h00;
  // bytes already used by base parts and earlier entries, this entry and the reserved interrupt tail
  wire [7:0] fill = {1'b0, used} + `SDCIF_CHAN_BYTES + int_room;
  wire       fits = fill <= `SDCIF_DIAG_MAX;
  wire       fire = valid && out_ready;
  wire [4:0] id_num = c_slot - 5'h01;
  // the byte register is loaded for the index that stands after this edge,
  // so an accepted byte is never offered a second time
  wire [3:0] sel_idx = (fire && !out_last) ? idx + 4'h1 : idx;
  reg  [7:0] next_byte;
  always @* begin
    next_byte = 8'h00;
    if (!is_int) begin
      case (sel_idx)
        4'h0: next_byte = {`SDCIF_CHAN_CODE, 1'b0, id_num};
        4'h1: next_byte = {c_dir, c_chan};
        4'h2: next_byte = {c_type, c_err};
        default: next_byte = 8'h00;
      endcase
    end else begin
      case (sel_idx)
        4'h0: next_byte = {`SDCIF_INT_CODE, `SDCIF_INT_LEN};
        4'h1: next_byte = {1'b0, `SDCIF_INT_TYPE_DIAG};
        4'h2: next_byte = {3'h0, i_slot};
        4'h3: next_byte = {seq, 1'b0, i_leave ? `SDCIF_ST_OUT : `SDCIF_ST_IN};
        4'h4: next_byte = {7'h00, i_fault};
        4'h5: next_byte = {4'h0, i_ana ? `SDCIF_CLS_ANA : `SDCIF_CLS_DIG};
        4'h6: next_byte = {6'h1C, i_kind};
        4'h7: next_byte = i_nch;
        4'h8: next_byte = i_addr[15:8];
        4'h9: next_byte = i_addr[7:0];
        4'hA: next_byte = i_evt[7:0];
        4'hB: next_byte = i_evt[15:8];
        default: next_byte = 8'h00;
      endcase
    end
  end
  wire last_idx = is_int ? (sel_idx == 4'hB) : (sel_idx == 4'h2);
  // ----------------------------------------------------------------
  // register port and framing
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      int_en   <= 1'b0;
      base_len <= 7'h00;
      chan_ena <= 20'h00000;
      c_slot   <= 5'h00;
      c_chan   <= 6'h00;
      c_dir    <= 2'h0;
      c_err    <= 5'h00;
      c_type   <= 3'h0;
      i_slot   <= 5'h00;
      i_leave  <= 1'b0;
      i_fault  <= 1'b0;
      i_ana    <= 1'b0;
      i_kind   <= 2'h0;
      i_nch    <= 8'h00;
      i_addr   <= 16'h0000;
      i_evt    <= 16'h0000;
      i_pend   <= 1'b0;
      seq      <= 5'h00;
      used     <= 7'h00;
      dropped  <= 8'h00;
      busy     <= 1'b0;
      is_int   <= 1'b0;
      idx      <= 4'h0;
      sent_int <= 1'b0;
      valid    <= 1'b0;
      out_data <= 8'h00;
      out_last <= 1'b0;
      rdata    <= 32'h00000000;
    end else begin
      rdata <= 32'h00000000;
      if (rd) begin
        case (addr)
          `SDCIF_A_CTRL: rdata <= {31'h0, int_en};
          `SDCIF_A_ENA:  rdata <= {12'h0, chan_ena};
          `SDCIF_A_BASE: rdata <= {25'h0, base_len};
          `SDCIF_A_STAT: rdata <= {14'h0, dropped, used, sent_int, i_pend, busy};
          `SDCIF_A_SEQ:  rdata <= {27'h0, seq + 5'h01};
          default:       rdata <= 32'h00000000;
        endcase
      end
      if (wr) begin
        case (addr)
          `SDCIF_A_CTRL: int_en <= wdata[0];
          `SDCIF_A_ENA:  chan_ena <= wdata[19:0];
          `SDCIF_A_BASE: if (!busy) begin
            base_len <= wdata[6:0];
            used <= wdata[6:0];
            sent_int <= 1'b0;
          end
          `SDCIF_A_CHAN: begin
            c_slot <= wdata[4:0];
            c_chan <= wdata[13:8];
            c_dir  <= wdata[15:14];
            c_err  <= wdata[20:16];
            c_type <= wdata[23:21];
          end
          `SDCIF_A_INT0: begin
            i_slot  <= wdata[4:0];
            i_leave <= wdata[8];
            i_fault <= wdata[9];
            i_ana   <= wdata[10];
            i_kind  <= wdata[13:12];
            i_nch   <= wdata[23:16];
            i_pend  <= 1'b1;
          end
          `SDCIF_A_INT1: begin
            i_addr <= wdata[31:16];
            i_evt <= wdata[15:0];
          end
          `SDCIF_A_START: if (!busy) begin
            if (wdata[0]) begin
              // channel entry: skipped and counted in dropped if disabled, out of room or after the interrupt section was sent
              if (chan_ok && fits && !sent_int) begin
                // valid follows one cycle later, once the first byte is loaded
                busy   <= 1'b1;
                is_int <= 1'b0;
                idx    <= 4'h0;
                used   <= used + 7'h03;
              end else begin
                dropped <= dropped + 8'h01;
              end
            end else if (wdata[1] && int_en && i_pend && !sent_int) begin
              busy     <= 1'b1;
              is_int   <= 1'b1;
              idx      <= 4'h0;
              sent_int <= 1'b1;
              seq <= (seq == `SDCIF_SEQ_MAX) ? 5'h00 : seq + 5'h01;
            end
          end
          default: ;
        endcase
      end
      if (busy) begin
        // seq has already advanced at start, so it is the number being sent
        out_data <= next_byte;
        out_last <= last_idx;
        if (!valid) valid <= 1'b1;
        if (fire) begin
          if (out_last) begin
            busy <= 1'b0;
            valid <= 1'b0;
            if (is_int) i_pend <= 1'b0;
          end else begin
            idx <= idx + 4'h1;
          end
        end
      end
    end
  end
endmodule

// ===== sdcif_monitor.sv
// stream checker for the diagnostic framer
`timescale 1ns/1ps
module sdcif_monitor (
  input wire       clk,
  input wire       nrst,
  input wire       out_valid,
  input wire       out_ready,
  input wire [7:0] out_data,
  input wire       out_last
);
  logic [3:0] idx;
  logic       intk;
  wire        acc = out_valid && out_ready;
  // idx counts accepted bytes within one unit; intk marks an interrupt unit
  always @(posedge clk) begin
    if (!nrst) begin
      idx  <= 4'h0;
      intk <= 1'b0;
    end else if (acc) begin
      idx <= out_last ? 4'h0 : idx + 4'h1;
      if (idx == 4'h0) intk <= (out_data == 8'h14);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_unit_len: assert property (
    acc && out_last |-> idx == (intk ? 4'hB : 4'h2)) else $error("bad unit length");
  chk_head_code: assert property (
    acc && idx == 4'h0 |-> out_data[7:6] == 2'h2 || out_data == 8'h14) else $error("bad head");
  chk_mod_id: assert property (
    acc && idx == 4'h0 && out_data[7:6] == 2'h2 |-> out_data[5:0] < 6'h14) else $error("bad id");
  chk_int_type: assert property (
    acc && intk && idx == 4'h1 |-> out_data[6:0] == 7'h01) else $error("bad type");
  chk_int_slot: assert property (
    acc && intk && idx == 4'h2 |-> out_data inside {[8'h01:8'h14]}) else $error("bad slot");
  chk_seq_state: assert property (
    acc && intk && idx == 4'h3 |-> !out_data[2] && out_data[1:0] inside {2'h1, 2'h2})
    else $error("bad state byte");
  chk_mod_class: assert property (
    acc && intk && idx == 4'h5 |-> out_data[3:0] inside {4'hF, 4'h5}) else $error("bad class");
  chk_mod_kind: assert property (
    acc && intk && idx == 4'h6 |-> out_data inside {[8'h70:8'h73]}) else $error("bad kind");
  cover property (acc && out_last && !intk);
  cover property (acc && out_last && intk);
  cover property (out_valid && !out_ready && $past(out_valid));
endmodule
bind sdcif_framer sdcif_monitor i_sdcif_monitor (.clk(clk), .nrst(nrst), .out_valid(out_valid),
  .out_ready(out_ready), .out_data(out_data), .out_last(out_last));

// ===== sdcif_rd_model.sv
// far-side reader that collects the framer byte stream
`timescale 1ns/1ps
module sdcif_rd_model (
  input  wire       clk,
  input  wire       nrst,
  input  wire       stall,
  input  wire       out_valid,
  input  wire [7:0] out_data,
  input  wire       out_last,
  output logic      out_ready
);
  logic [7:0] got[$];
  logic       tog;
  always @(posedge clk) begin
    if (!nrst) begin
      out_ready <= 1'b0;
      tog       <= 1'b0;
    end else begin
      tog <= !tog;
      if (out_valid && out_ready) got.push_back(out_data);
      // ready lags valid: the first valid cycle carries no byte yet
      out_ready <= out_valid && !(out_ready && out_last) && !(stall && tog);
    end
  end
endmodule

// ===== test_slave_diag_channel_interrupt_framer.sv
// self-checking bench for the diagnostic framer
`timescale 1ns/1ps
module test_slave_diag_channel_interrupt_framer;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        stall = 1'b0;
  logic [31:0] rdata;
  logic        out_valid, out_ready, out_last;
  logic [7:0]  out_data;
  logic [7:0]  ex[$];
  logic [4:0]  seq = 5'h01;
  logic [4:0]  errs[6] = '{5'h01, 5'h09, 5'h10, 5'h11, 5'h12, 5'h04};
  int          num_errors = 0;
  int          tests_run = 0;
  initial begin
    forever #5 clk = ~clk;
  end
  sdcif_framer i_sdcif_framer (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data), .out_last(out_last));
  sdcif_rd_model i_sdcif_rd_model (.clk(clk), .nrst(nrst), .stall(stall),
    .out_valid(out_valid), .out_data(out_data), .out_last(out_last), .out_ready(out_ready));
  task results;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rreg(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e, "read");
  endtask
  // waits for the expected bytes, then a while longer to catch surplus ones
  task take(input logic [7:0] m1);
    int i;
    i = 0;
    while (i_sdcif_rd_model.got.size() < ex.size() && i < 300) begin
      @(posedge clk);
      i++;
    end
    if (i == 300) begin
      num_errors++;
      results;
    end
    repeat (8) @(posedge clk);
    chk(i_sdcif_rd_model.got.size(), ex.size(), "count");
    foreach (ex[k]) chk(i_sdcif_rd_model.got[k] & (k == 1 ? m1 : 8'hFF), ex[k], "byte");
    ex.delete();
    i_sdcif_rd_model.got.delete();
  endtask
  task chan(input logic [4:0] s, input logic [5:0] c, input logic [1:0] d,
    input logic [4:0] e, input logic [2:0] t, input bit ok);
    wreg(4'h3, {8'h00, t, e, d, c, 3'h0, s});
    wreg(4'h7, 32'h1);
    if (ok) ex = '{{2'h2, 1'b0, s - 5'h01}, {d, c}, {t, e}};
    take(8'hFF);
  endtask
  task intr(input bit lv, input bit an, input logic [1:0] k, input logic [15:0] ev);
    wreg(4'h4, {8'h00, 8'h05, 2'h0, k, 1'b0, an, 1'b1, lv, 3'h0, 5'h07});
    wreg(4'h5, {16'h2A5C, ev});
    wreg(4'h7, 32'h2);
    ex = '{8'h14, 8'h01, 8'h07, {seq, 1'b0, lv ? 2'h2 : 2'h1}, 8'h01, an ? 8'h05 : 8'h0F,
      8'h70 + k, 8'h05, 8'h2A, 8'h5C, ev[7:0], ev[15:8]};
    take(8'h7F);
    seq++;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rreg(4'h9, 32'h1);
    wreg(4'h0, 32'h1);
    wreg(4'h1, 32'h80001);
    wreg(4'h2, 32'hA);
    foreach (errs[i]) chan(i[0] ? 5'h14 : 5'h01, 6'(i * 6), 2'(i % 3 + 1), errs[i], 3'(i + 1), 1'b1);
    chan(5'h02, 6'h1F, 2'h1, 5'h01, 3'h1, 1'b0);
    wreg(4'h2, 32'h70);
    chan(5'h01, 6'h03, 2'h2, 5'h02, 3'h4, 1'b1);
    chan(5'h01, 6'h04, 2'h2, 5'h02, 3'h4, 1'b0);
    stall <= 1'b1;
    intr(1'b0, 1'b1, 2'h1, 16'h8001);
    chan(5'h01, 6'h05, 2'h1, 5'h01, 3'h1, 1'b0);
    wreg(4'h7, 32'h2);
    take(8'h7F);
    rreg(4'h9, 32'h2);
    wreg(4'h2, 32'h0);
    intr(1'b1, 1'b0, 2'h2, 16'h0100);
    results;
  end
endmodule
